// file: aie_add_execute.sv
// Execute unit for add-literal and add-to-file instructions, AXI4-Lite slave
// Assumes a data memory whose read data is valid one cycle after the address
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`include "aie_defines.svh"

// How it works
// - Add-to-file sums accumulator and addressed register, updating N, OV, C, DC, Z.
// - Destination bit clear puts the sum in the accumulator, register untouched.
// - Destination bit set writes the sum back into the addressed register.
// - Bank bit clear addresses the fixed access bank, ignoring bank select.
// - Bank bit set forms the address from bank select and the operand.
// - Extended set with bank bit clear indexes operands up to 95.
module aie_add_execute
  import aie_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [11:0]      dataAddr,
  input  wire logic [7:0]  dataRdData,
  output logic             dataWrEn,
  output logic [7:0]       dataWrData
);

  // ***************************************************
  // State
  // ***************************************************
  aie_phase_t  phase,      next_phase;
  logic [15:0] instr,      next_instr;
  logic [7:0]  acc,        next_acc;
  logic [4:0]  flags,      next_flags;
  logic [4:0]  pendFlags,  next_pendFlags;
  logic [3:0]  bank,       next_bank;
  logic        extEn,      next_extEn;
  logic [11:0] indexBase,  next_indexBase;
  logic        badOp,      next_badOp;
  logic [11:0] next_dataAddr;
  logic        next_dataWrEn;
  logic [7:0]  next_dataWrData;
  logic        awHeld,     next_awHeld;
  logic [7:0]  awAddrReg,  next_awAddrReg;
  logic        wHeld,      next_wHeld;
  logic [31:0] wDataReg,   next_wDataReg;
  logic [3:0]  wStrbReg,   next_wStrbReg;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;

  logic        busy;
  logic        isLit;
  logic        isFile;
  logic [7:0]  addend;
  logic [7:0]  sum;
  logic [4:0]  sumFlags;
  logic [11:0] fileAddr;
  logic        fileIndexed;
  logic [7:0]  wrOfs;
  logic [7:0]  rdOfs;
  logic [15:0] indexLane;

  // ***************************************************
  // Datapath
  // ***************************************************
  assign busy   = phase != AIE_IDLE;
  assign isLit  = aieIsAddLiteral(instr);
  assign isFile = aieIsAddFile(instr);
  assign addend = isLit ? instr[7:0] : dataRdData;

  aie_adder u_adder (
    .addendA (acc),
    .addendB (addend),
    .sum     (sum),
    .flags   (sumFlags)
  );

  aie_addr_gen u_addr_gen (
    .fileOperand (instr[7:0]),
    .bankAccess  (instr[`AIE_BANK_BIT]),
    .bankSelect  (bank),
    .extendedSet (extEn),
    .indexBase   (indexBase),
    .dataAddress (fileAddr),
    .indexed     (fileIndexed)
  );

  // ***************************************************
  // Bus handshakes
  // ***************************************************
  assign awready = ce && !awHeld && !bvalid;
  assign wready  = ce && !wHeld && !bvalid;
  assign arready = ce && !rvalid;
  assign wrOfs   = {awAddrReg[7:2], 2'h0};
  assign rdOfs   = {araddr[7:2], 2'h0};
  assign indexLane = aieLane16({4'h0, indexBase}, wDataReg, wStrbReg);

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    next_phase      = phase;
    next_instr      = instr;
    next_acc        = acc;
    next_flags      = flags;
    next_pendFlags  = pendFlags;
    next_bank       = bank;
    next_extEn      = extEn;
    next_indexBase  = indexBase;
    next_badOp      = badOp;
    next_dataAddr   = dataAddr;
    next_dataWrEn   = 1'b0;
    next_dataWrData = dataWrData;
    next_awHeld     = awHeld;
    next_awAddrReg  = awAddrReg;
    next_wHeld      = wHeld;
    next_wDataReg   = wDataReg;
    next_wStrbReg   = wStrbReg;
    next_bresp      = bresp;
    next_bvalid     = bvalid;
    next_rdata      = rdata;
    next_rresp      = rresp;
    next_rvalid     = rvalid;

    // Quarter-cycle sequence
    unique case (phase)
      AIE_IDLE: begin
      end
      AIE_Q1: begin
        if (isLit || isFile) begin
          next_badOp    = 1'b0;
          next_dataAddr = isFile ? fileAddr : dataAddr;
          next_phase    = AIE_Q2;
        end else begin
          next_badOp = 1'b1;
          next_phase = AIE_IDLE;
        end
      end
      AIE_Q2: begin
        next_phase = AIE_Q3;
      end
      AIE_Q3: begin
        next_dataWrData = sum;
        next_pendFlags  = sumFlags;
        next_dataWrEn   = isFile && instr[`AIE_DEST_BIT];
        next_phase      = AIE_Q4;
      end
      AIE_Q4: begin
        next_flags = pendFlags;
        if (isLit || !instr[`AIE_DEST_BIT]) begin
          next_acc = dataWrData;
        end
        next_phase = AIE_IDLE;
      end
    endcase

    // Write channel
    if (awvalid && awready) begin
      next_awHeld    = 1'b1;
      next_awAddrReg = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld    = 1'b1;
      next_wDataReg = wdata;
      next_wStrbReg = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (awHeld && wHeld && !bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `AIE_RESP_OKAY;
      if (busy) begin
        next_bresp = `AIE_RESP_SLVERR;
      end else begin
        unique case (wrOfs)
          `AIE_OFS_INSTR: begin
            next_instr = aieLane16(instr, wDataReg, wStrbReg);
            next_phase = AIE_Q1;
          end
          `AIE_OFS_ACC:   if (wStrbReg[0]) next_acc = wDataReg[7:0];
          `AIE_OFS_FLAGS: if (wStrbReg[0]) next_flags = wDataReg[4:0];
          `AIE_OFS_BANK:  if (wStrbReg[0]) next_bank = wDataReg[3:0];
          `AIE_OFS_CTRL:  if (wStrbReg[0]) next_extEn = wDataReg[`AIE_CTRL_EXT];
          `AIE_OFS_INDEX: next_indexBase = indexLane[11:0];
          `AIE_OFS_STAT:  next_bresp = `AIE_RESP_SLVERR;
          default:        next_bresp = `AIE_RESP_DECERR;
        endcase
      end
    end

    // Read channel
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `AIE_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (rdOfs)
        `AIE_OFS_INSTR: next_rdata[15:0] = instr;
        `AIE_OFS_ACC:   next_rdata[7:0]  = acc;
        `AIE_OFS_FLAGS: next_rdata[4:0]  = flags;
        `AIE_OFS_BANK:  next_rdata[3:0]  = bank;
        `AIE_OFS_CTRL:  next_rdata[`AIE_CTRL_EXT] = extEn;
        `AIE_OFS_INDEX: next_rdata[11:0] = indexBase;
        `AIE_OFS_STAT: begin
          next_rdata[`AIE_STAT_BUSY]  = busy;
          next_rdata[`AIE_STAT_BADOP] = badOp;
        end
        default:        next_rresp = `AIE_RESP_DECERR;
      endcase
    end
  end

  // ***************************************************
  // Registers
  // ***************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase      <= AIE_IDLE;
      instr      <= `AIE_RST_INSTR;
      acc        <= `AIE_RST_ACC;
      flags      <= `AIE_RST_FLAGS;
      pendFlags  <= `AIE_RST_FLAGS;
      bank       <= `AIE_RST_BANK;
      extEn      <= `AIE_RST_CTRL;
      indexBase  <= `AIE_RST_INDEX;
      badOp      <= 1'b0;
      dataAddr   <= 12'h000;
      dataWrEn   <= 1'b0;
      dataWrData <= 8'h00;
      awHeld     <= 1'b0;
      awAddrReg  <= 8'h00;
      wHeld      <= 1'b0;
      wDataReg   <= 32'h0000_0000;
      wStrbReg   <= 4'h0;
      bresp      <= `AIE_RESP_OKAY;
      bvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= `AIE_RESP_OKAY;
      rvalid     <= 1'b0;
    end else if (ce) begin
      phase      <= next_phase;
      instr      <= next_instr;
      acc        <= next_acc;
      flags      <= next_flags;
      pendFlags  <= next_pendFlags;
      bank       <= next_bank;
      extEn      <= next_extEn;
      indexBase  <= next_indexBase;
      badOp      <= next_badOp;
      dataAddr   <= next_dataAddr;
      dataWrEn   <= next_dataWrEn;
      dataWrData <= next_dataWrData;
      awHeld     <= next_awHeld;
      awAddrReg  <= next_awAddrReg;
      wHeld      <= next_wHeld;
      wDataReg   <= next_wDataReg;
      wStrbReg   <= next_wStrbReg;
      bresp      <= next_bresp;
      bvalid     <= next_bvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
      rvalid     <= next_rvalid;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_file_sum_flags: assert property (
    (ce && phase == AIE_Q3 && isFile) |=>
      (dataWrData == 8'($past(acc) + $past(dataRdData))) &&
      (pendFlags[`AIE_FLAG_Z] == (dataWrData == 8'h00)) &&
      (pendFlags[`AIE_FLAG_N] == dataWrData[7]))
    else $error("file add sum or flags wrong");

  chk_dest_accum: assert property (
    (ce && phase == AIE_Q4 && isFile && !instr[`AIE_DEST_BIT]) |->
      !dataWrEn ##1 (acc == $past(dataWrData)))
    else $error("accumulator destination not honoured");

  chk_dest_file: assert property (
    (ce && phase == AIE_Q4 && isFile && instr[`AIE_DEST_BIT]) |->
      dataWrEn ##1 ($stable(acc) && !dataWrEn))
    else $error("file destination not honoured");

  chk_access_bank: assert property (
    (phase == AIE_Q2 && isFile && !instr[`AIE_BANK_BIT] &&
     !(extEn && instr[7:0] <= `AIE_INDEX_LIMIT)) |->
      dataAddr == {(instr[7:0] < `AIE_ACCESS_SPLIT) ? `AIE_ACCESS_LOBANK : `AIE_ACCESS_HIBANK, instr[7:0]})
    else $error("access bank address wrong");

  chk_banked_addr: assert property (
    (phase == AIE_Q2 && isFile && instr[`AIE_BANK_BIT]) |-> dataAddr == {bank, instr[7:0]})
    else $error("banked address wrong");

  chk_indexed_addr: assert property (
    (phase == AIE_Q2 && isFile && !instr[`AIE_BANK_BIT] && extEn && instr[7:0] <= `AIE_INDEX_LIMIT) |->
      dataAddr == 12'(indexBase + {4'h0, instr[7:0]}))
    else $error("indexed address wrong");

  chk_literal_cycle: assert property (
    (ce && phase == AIE_Q1 && isLit) ##1 ce[*3] |=>
      (phase == AIE_IDLE) && (acc == 8'($past(acc) + $past(instr[7:0]))) &&
      (flags[`AIE_FLAG_Z] == (acc == 8'h00)) && !$past(dataWrEn))
    else $error("literal add wrong or late");

endmodule

// file: aie_defines.svh
// Constants of the add-instruction execute block
// Assumes inclusion by bare name from the package and the design modules
`ifndef AIE_DEFINES_SVH
`define AIE_DEFINES_SVH

// ***************************************************
// Register offsets (byte addresses, one word each)
// ***************************************************
`define AIE_OFS_INSTR 8'h00
`define AIE_OFS_ACC   8'h04
`define AIE_OFS_FLAGS 8'h08
`define AIE_OFS_BANK  8'h0C
`define AIE_OFS_CTRL  8'h10
`define AIE_OFS_INDEX 8'h14
`define AIE_OFS_STAT  8'h18

// ***************************************************
// Field positions
// ***************************************************
`define AIE_FLAG_C     0
`define AIE_FLAG_DC    1
`define AIE_FLAG_Z     2
`define AIE_FLAG_OV    3
`define AIE_FLAG_N     4
`define AIE_CTRL_EXT   0
`define AIE_STAT_BUSY  0
`define AIE_STAT_BADOP 1
`define AIE_DEST_BIT   9
`define AIE_BANK_BIT   8

// ***************************************************
// Encodings and limits
// ***************************************************
`define AIE_OP_ADD_LITERAL_TO_ACCUMULATOR      8'h0F
`define AIE_OP_ADD_ACCUMULATOR_TO_FILE      6'h09
`define AIE_INDEX_LIMIT   8'h5F
`define AIE_ACCESS_SPLIT  8'h60
`define AIE_ACCESS_HIBANK 4'hF
`define AIE_ACCESS_LOBANK 4'h0
`define AIE_RESP_OKAY     2'h0
`define AIE_RESP_SLVERR   2'h2
`define AIE_RESP_DECERR   2'h3

// ***************************************************
// Reset values
// ***************************************************
`define AIE_RST_INSTR 16'h0000
`define AIE_RST_ACC   8'h00
`define AIE_RST_FLAGS 5'h00
`define AIE_RST_BANK  4'h0
`define AIE_RST_CTRL  1'b0
`define AIE_RST_INDEX 12'h000

`endif

// file: aie_pkg.sv
// Types and shared decode functions of the add-instruction execute block
// Assumes aie_defines.svh on the include path
`include "aie_defines.svh"

package aie_pkg;

  typedef enum logic [2:0] {AIE_IDLE, AIE_Q1, AIE_Q2, AIE_Q3, AIE_Q4} aie_phase_t;

  function automatic logic aieIsAddLiteral(input logic [15:0] word);
    return word[15:8] == `AIE_OP_ADD_LITERAL_TO_ACCUMULATOR;
  endfunction

  function automatic logic aieIsAddFile(input logic [15:0] word);
    return word[15:10] == `AIE_OP_ADD_ACCUMULATOR_TO_FILE;
  endfunction

  function automatic logic [15:0] aieLane16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

endpackage

// file: aie_adder.sv
// Eight-bit adder with the five arithmetic flags
// Assumes purely combinational use inside the execute block
`include "aie_defines.svh"

module aie_adder
  import aie_pkg::*;
(
  input  wire logic [7:0] addendA,
  input  wire logic [7:0] addendB,
  output logic      [7:0] sum,
  output logic      [4:0] flags
);

  logic [8:0] full;
  logic [4:0] half;

  always_comb begin
    full                 = {1'b0, addendA} + {1'b0, addendB};
    half                 = {1'b0, addendA[3:0]} + {1'b0, addendB[3:0]};
    sum                  = full[7:0];
    flags                = 5'h00;
    flags[`AIE_FLAG_C]   = full[8];
    flags[`AIE_FLAG_DC]  = half[4];
    flags[`AIE_FLAG_Z]   = full[7:0] == 8'h00;
    flags[`AIE_FLAG_OV]  = (addendA[7] == addendB[7]) && (full[7] != addendA[7]);
    flags[`AIE_FLAG_N]   = full[7];
  end

endmodule

// file: aie_addr_gen.sv
// Data address former for the add-to-file operand
// Assumes a 12-bit data space of sixteen 256-byte banks
`include "aie_defines.svh"

module aie_addr_gen
  import aie_pkg::*;
(
  input  wire logic [7:0]  fileOperand,
  input  wire logic        bankAccess,
  input  wire logic [3:0]  bankSelect,
  input  wire logic        extendedSet,
  input  wire logic [11:0] indexBase,
  output logic      [11:0] dataAddress,
  output logic             indexed
);

  always_comb begin
    indexed = extendedSet && !bankAccess && (fileOperand <= `AIE_INDEX_LIMIT);
    if (indexed) begin
      dataAddress = 12'(indexBase + {4'h0, fileOperand});
    end else if (bankAccess) begin
      dataAddress = {bankSelect, fileOperand};
    end else if (fileOperand < `AIE_ACCESS_SPLIT) begin
      dataAddress = {`AIE_ACCESS_LOBANK, fileOperand};
    end else begin
      dataAddress = {`AIE_ACCESS_HIBANK, fileOperand};
    end
  end

endmodule

// file: add_instruction_execute_test.sv
// Self-checking bench of the add-instruction execute unit
// Assumes aie_defines.svh on the include path and aie_pkg compiled first
`include "aie_defines.svh"

module add_instruction_execute_test
  import aie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [11:0] dataAddr;
  logic [7:0]  dataRdData = 8'h00;
  logic        dataWrEn;
  logic [7:0]  dataWrData;
  logic [7:0]  mem [0:4095];
  int          wrCount = 0;
  int          failures = 0;
  int          checkCount = 0;
  logic [31:0] rd;

  always #2.5 clk = ~clk;

  aie_add_execute DUT (.clk(clk), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dataAddr(dataAddr), .dataRdData(dataRdData), .dataWrEn(dataWrEn), .dataWrData(dataWrData));

  // ***************************************************
  // Data memory with one cycle read latency
  // ***************************************************
  always @(posedge clk) begin
    dataRdData <= mem[dataAddr];
    if (dataWrEn === 1'b1) begin
      mem[dataAddr] <= dataWrData;
      wrCount <= wrCount + 1;
    end
  end

  // ***************************************************
  // Checking and closing
  // ***************************************************
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // ***************************************************
  // Bus tasks, entered and left just after a rising edge
  // ***************************************************
  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb,
                          input logic [1:0] expResp);
    logic awDone, wDone, tA, tW, tB;
    logic [1:0] resp;
    awaddr <= addr;
    wdata <= data;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awDone = 1'b0;
    wDone = 1'b0;
    tB = 1'b0;
    while (!(awDone && wDone)) begin
      @(negedge clk);
      tA = awvalid && awready;
      tW = wvalid && wready;
      @(posedge clk);
      if (tA) begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (tW) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    while (!tB) begin
      @(negedge clk);
      tB = (bvalid === 1'b1);
      resp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    @(posedge clk);
    cmpResp(resp, expResp);
  endtask

  task automatic axiRead(input logic [7:0] addr, input logic [1:0] expResp, output logic [31:0] data);
    logic tA, tR;
    logic [1:0] resp;
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tA = 1'b0;
    tR = 1'b0;
    while (!tA) begin
      @(negedge clk);
      tA = arvalid && arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    while (!tR) begin
      @(negedge clk);
      tR = (rvalid === 1'b1);
      data = rdata;
      resp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
    @(posedge clk);
    cmpResp(resp, expResp);
  endtask

  // ***************************************************
  // Instruction helpers
  // ***************************************************
  function automatic logic [4:0] expFlags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] f;
    s = {1'b0, a} + {1'b0, b};
    f = 5'h00;
    f[`AIE_FLAG_C] = s[8];
    f[`AIE_FLAG_DC] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    f[`AIE_FLAG_Z] = (s[7:0] == 8'h00);
    f[`AIE_FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    f[`AIE_FLAG_N] = s[7];
    return f;
  endfunction

  task automatic execute(input logic [15:0] word);
    int n;
    axiWrite(`AIE_OFS_INSTR, {16'h0000, word}, 4'h3, `AIE_RESP_OKAY);
    n = 0;
    rd = 32'h1;
    while (rd[`AIE_STAT_BUSY] !== 1'b0 && n < 20) begin
      axiRead(`AIE_OFS_STAT, `AIE_RESP_OKAY, rd);
      n++;
    end
    cmpWord({31'h0, rd[`AIE_STAT_BUSY]}, 32'h0);
  endtask

  task automatic runLiteral(input logic [7:0] accIn, input logic [7:0] k);
    axiWrite(`AIE_OFS_ACC, {24'h0, accIn}, 4'h1, `AIE_RESP_OKAY);
    execute({`AIE_OP_ADD_LITERAL_TO_ACCUMULATOR, k});
    axiRead(`AIE_OFS_ACC, `AIE_RESP_OKAY, rd);
    cmpWord(rd, {24'h0, accIn + k});
    axiRead(`AIE_OFS_FLAGS, `AIE_RESP_OKAY, rd);
    cmpWord(rd, {27'h0, expFlags(accIn, k)});
  endtask

  task automatic runFile(input logic [7:0] accIn, input logic [7:0] f, input logic d, input logic a,
                         input logic [3:0] bank, input logic ext, input logic [11:0] addr,
                         input logic [7:0] opnd);
    logic [7:0] sum;
    int w0;
    sum = accIn + opnd;
    mem[addr] = opnd;
    w0 = wrCount;
    axiWrite(`AIE_OFS_ACC, {24'h0, accIn}, 4'h1, `AIE_RESP_OKAY);
    axiWrite(`AIE_OFS_BANK, {28'h0, bank}, 4'h1, `AIE_RESP_OKAY);
    axiWrite(`AIE_OFS_CTRL, {31'h0, ext}, 4'h1, `AIE_RESP_OKAY);
    execute({`AIE_OP_ADD_ACCUMULATOR_TO_FILE, d, a, f});
    cmpWord({20'h0, dataAddr}, {20'h0, addr});
    axiRead(`AIE_OFS_ACC, `AIE_RESP_OKAY, rd);
    cmpWord(rd, {24'h0, d ? accIn : sum});
    axiRead(`AIE_OFS_FLAGS, `AIE_RESP_OKAY, rd);
    cmpWord(rd, {27'h0, expFlags(accIn, opnd)});
    cmpWord({24'h0, mem[addr]}, {24'h0, d ? sum : opnd});
    cmpWord(32'(wrCount - w0), {31'h0, d});
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 1; i < 7; i++) begin
      axiRead(8'(4 * i), `AIE_RESP_OKAY, rd);
      cmpWord(rd, 32'h0);
    end
    axiRead(8'h1C, `AIE_RESP_DECERR, rd);
    cmpWord(rd, 32'h0);
    axiWrite(8'h1C, 32'h0, 4'hF, `AIE_RESP_DECERR);
    axiWrite(`AIE_OFS_STAT, 32'h3, 4'hF, `AIE_RESP_SLVERR);
    // Unknown opcode only raises the bad-opcode status
    axiWrite(`AIE_OFS_INSTR, 32'h0, 4'h3, `AIE_RESP_OKAY);
    axiRead(`AIE_OFS_STAT, `AIE_RESP_OKAY, rd);
    cmpWord(rd, 32'h1 << `AIE_STAT_BADOP);
    // Clock enable low freezes execution and blocks the bus
    axiWrite(`AIE_OFS_ACC, 32'h20, 4'h1, `AIE_RESP_OKAY);
    axiWrite(`AIE_OFS_INSTR, {16'h0, `AIE_OP_ADD_LITERAL_TO_ACCUMULATOR, 8'h03}, 4'h3, `AIE_RESP_OKAY);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    cmpWord({29'h0, awready, wready, arready}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    axiRead(`AIE_OFS_STAT, `AIE_RESP_OKAY, rd);
    cmpWord(rd, 32'h1 << `AIE_STAT_BUSY);
    axiRead(`AIE_OFS_ACC, `AIE_RESP_OKAY, rd);
    cmpWord(rd, 32'h23);
    runLiteral(8'h10, 8'h15);
    runLiteral(8'hFF, 8'h01);
    runLiteral(8'h7F, 8'h01);
    runLiteral(8'h80, 8'h80);
    axiWrite(`AIE_OFS_INDEX, 32'h200, 4'h3, `AIE_RESP_OKAY);
    runFile(8'h17, 8'h10, 1'b0, 1'b0, 4'h5, 1'b0, 12'h010, 8'hC2);
    runFile(8'h0F, 8'h60, 1'b1, 1'b0, 4'h5, 1'b0, 12'hF60, 8'h01);
    runFile(8'h80, 8'h80, 1'b1, 1'b1, 4'h5, 1'b0, 12'h580, 8'h80);
    runFile(8'h01, 8'h33, 1'b0, 1'b1, 4'hA, 1'b1, 12'hA33, 8'hFF);
    runFile(8'h08, 8'h5F, 1'b1, 1'b0, 4'h5, 1'b1, 12'h25F, 8'h08);
    runFile(8'h20, 8'h00, 1'b0, 1'b0, 4'h5, 1'b1, 12'h200, 8'h40);
    runFile(8'h44, 8'h60, 1'b0, 1'b0, 4'h5, 1'b1, 12'hF60, 8'h11);
    give_verdict();
  end
endmodule
